// [rtl/iolc_defines.vh]
`ifndef IOLC_DEFINES_VH
`define IOLC_DEFINES_VH

// opcode classes presented by the decode front end
`define IOLC_CLS_ADD        5'h00
`define IOLC_CLS_ADC        5'h01
`define IOLC_CLS_AND        5'h02
`define IOLC_CLS_ADJ_ADD    5'h03
`define IOLC_CLS_ADJ_DIV    5'h04
`define IOLC_CLS_ADJ_MUL    5'h05
`define IOLC_CLS_ADJ_SUB    5'h06
`define IOLC_CLS_PD_ADD     5'h07
`define IOLC_CLS_EA_CALC    5'h08
`define IOLC_CLS_NOP        5'h09
`define IOLC_CLS_INT_MUL    5'h0a
`define IOLC_CLS_PIPE2_OP   5'h0b
`define IOLC_CLS_WC_MOVE    5'h0c
`define IOLC_CLS_SIZED_OP   5'h0d
`define IOLC_CLS_FSTACK_OP  5'h0e
`define IOLC_CLS_BIT_OP     5'h0f

// decode path codes, ordered by complexity
`define IOLC_PATH_SINGLE    2'h0
`define IOLC_PATH_DUAL      2'h1
`define IOLC_PATH_MICRO     2'h2

// operand size and precision selectors
`define IOLC_SZ_16          2'h0
`define IOLC_SZ_32          2'h1
`define IOLC_SZ_64          2'h2
`define IOLC_PC_SINGLE      2'h0
`define IOLC_PC_DOUBLE      2'h1
`define IOLC_PC_EXTENDED    2'h2

// pipe masks, bit n set means pipe n allowed
`define IOLC_PIPE_ANY       3'h7
`define IOLC_PIPE_ONLY0     3'h1
`define IOLC_PIPE_ONLY2     3'h4
`define IOLC_PIPE_NONE      3'h0

// latencies in cycles
`define IOLC_LAT_ALU_REG    8'h01
`define IOLC_LAT_ALU_MEM    8'h04
`define IOLC_LAT_ADJ        8'h05
`define IOLC_LAT_ADJ_MUL    8'h0e
`define IOLC_LAT_ADJ_MUL_LT 8'h0f
`define IOLC_LAT_PD_REG     8'h04
`define IOLC_LAT_LOAD_ADD   8'h02
`define IOLC_LAT_EA_SIMPLE  8'h01
`define IOLC_LAT_EA_COMPLEX 8'h02
`define IOLC_LAT_MUL_REG    8'h03
`define IOLC_LAT_MUL_MEM    8'h06
`define IOLC_LAT_BIT_REG    8'h02
`define IOLC_LAT_BIT_MEM    8'h05
`define IOLC_LAT_PIPE2      8'h01
`define IOLC_LAT_WC         8'h06
`define IOLC_LAT_SZ16       8'h01
`define IOLC_LAT_SZ32       8'h01
`define IOLC_LAT_SZ64       8'h01
`define IOLC_LAT_FP_SGL     8'h1a
`define IOLC_LAT_FP_DBL     8'h2a
`define IOLC_LAT_FP_EXT     8'h4a

// effective-address source count limit for the fast form
`define IOLC_EA_FAST_SRCS   2'h2

`endif

// [rtl/iolc_reset_sync.v]
`timescale 1ns/10ps
`default_nettype none

module iolc_reset_sync (
  // clock and raw reset
  input  wire mclk,
  input  wire rst_b,
  // released copy
  output wire rstSyncB
);

  reg stage1B;
  reg stage2B;

  ////////////////////////////////////////////////////////////////////////////
  // assert at once, release two edges later to avoid metastable release
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stage1B <= 1'b0;
      stage2B <= 1'b0;
    end else begin
      stage1B <= 1'b1;
      stage2B <= stage1B;
    end
  end

  assign rstSyncB = stage2B;

endmodule

`default_nettype wire

// [rtl/iolc_classifier.v]
// Operation
// - latency is dependent micro-op chain length
// - latencies assume cache hit, no contention
// - add/adc/and: single slot, 1 or 4
// - adjust ops microcode, 5; multiply 14/15
// - packed double add memory form adds 2
// - address calc 1, scaled or many 2
// - first restriction: pipe 0 only
// - second restriction: pipe 2 only
// - no-operation uses no execution resources
// - write-combining ops flag combining buffers
// - size-dependent latency picked by 16/32/64
// - stack float latency picked by precision
// - register or memory form selects latency
// - first register destination, second source
// - paths ordered, more complex means more micro-ops
`timescale 1ns/10ps
`include "iolc_defines.vh"
`default_nettype none

module iolc_classifier #(
  parameter CLS_W = 5,
  parameter LAT_W = 8,
  parameter REG_W = 4
) (
  // clock and reset
  input  wire             mclk,
  input  wire             rst_b,
  // request from the decode front end
  input  wire             reqValid,
  input  wire [CLS_W-1:0] opClass,
  input  wire             memForm,
  input  wire [1:0]       opSize,
  input  wire [1:0]       precCtl,
  input  wire             eaScaled,
  input  wire [1:0]       eaSrcCount,
  input  wire             laterVariant,
  input  wire [REG_W-1:0] firstReg,
  input  wire [REG_W-1:0] secondReg,
  // answer to the scheduler
  output reg              outValid,
  output reg  [1:0]       decodePath,
  output reg  [LAT_W-1:0] latency,
  output reg  [2:0]       pipeMask,
  output reg  [1:0]       uopSlots,
  output reg              allocExec,
  output reg              wcUse,
  output reg              unknownOp,
  output reg  [REG_W-1:0] dstReg,
  output reg  [REG_W-1:0] srcReg
);

  wire             rstSyncB;
  reg [1:0]        next_decodePath;
  reg [LAT_W-1:0]  next_latency;
  reg [2:0]        next_pipeMask;
  reg              next_allocExec;
  reg              next_wcUse;
  reg              next_unknownOp;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  iolc_reset_sync uResetSync (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .rstSyncB (rstSyncB)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers shared by several classes

  // three-way pick, out-of-range selector falls to the widest value
  function [LAT_W-1:0] selTriple;
    input [1:0]       sel;
    input [LAT_W-1:0] v0;
    input [LAT_W-1:0] v1;
    input [LAT_W-1:0] v2;
    begin
      case (sel)
        2'h0:    selTriple = v0;
        2'h1:    selTriple = v1;
        default: selTriple = v2;
      endcase
    end
  endfunction

  // register form first, memory form second
  function [LAT_W-1:0] selRegMem;
    input             isMem;
    input [LAT_W-1:0] regLat;
    input [LAT_W-1:0] memLat;
    begin
      selRegMem = isMem ? memLat : regLat;
    end
  endfunction

  // micro-op slot count grows with path complexity
  function [1:0] slotsOf;
    input [1:0] path;
    begin
      case (path)
        `IOLC_PATH_SINGLE: slotsOf = 2'h1;
        `IOLC_PATH_DUAL:   slotsOf = 2'h2;
        default:           slotsOf = 2'h3;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // class lookup; figures are isolated latencies, so cache misses and pipe
  // contention are the scheduler's problem, not encoded here
  always @* begin
    next_decodePath = `IOLC_PATH_SINGLE;
    next_latency    = `IOLC_LAT_ALU_REG;
    next_pipeMask   = `IOLC_PIPE_ANY;
    next_allocExec  = 1'b1;
    next_wcUse      = 1'b0;
    next_unknownOp  = 1'b0;
    case (opClass)
      `IOLC_CLS_ADD, `IOLC_CLS_ADC, `IOLC_CLS_AND: begin
        next_decodePath = `IOLC_PATH_SINGLE;
        next_latency    = selRegMem(memForm, `IOLC_LAT_ALU_REG,
                                    `IOLC_LAT_ALU_MEM);
      end
      `IOLC_CLS_ADJ_ADD, `IOLC_CLS_ADJ_DIV, `IOLC_CLS_ADJ_SUB: begin
        next_decodePath = `IOLC_PATH_MICRO;
        next_latency    = `IOLC_LAT_ADJ;
      end
      `IOLC_CLS_ADJ_MUL: begin
        next_decodePath = `IOLC_PATH_MICRO;
        next_latency    = laterVariant ? `IOLC_LAT_ADJ_MUL_LT
                                       : `IOLC_LAT_ADJ_MUL;
      end
      `IOLC_CLS_PD_ADD: begin
        // load part may overlap older work; reported figure is isolated
        next_latency = selRegMem(memForm, `IOLC_LAT_PD_REG,
                                 `IOLC_LAT_PD_REG
                                 + `IOLC_LAT_LOAD_ADD);
      end
      `IOLC_CLS_EA_CALC: begin
        if (eaScaled || (eaSrcCount > `IOLC_EA_FAST_SRCS)) begin
          next_latency = `IOLC_LAT_EA_COMPLEX;
        end else begin
          next_latency = `IOLC_LAT_EA_SIMPLE;
        end
      end
      `IOLC_CLS_NOP: begin
        next_pipeMask  = `IOLC_PIPE_NONE;
        next_allocExec = 1'b0;
        next_latency   = {LAT_W{1'b0}};
      end
      `IOLC_CLS_INT_MUL: begin
        next_pipeMask = `IOLC_PIPE_ONLY0;
        next_latency  = selRegMem(memForm, `IOLC_LAT_MUL_REG,
                                  `IOLC_LAT_MUL_MEM);
      end
      `IOLC_CLS_PIPE2_OP: begin
        next_pipeMask = `IOLC_PIPE_ONLY2;
        next_latency  = `IOLC_LAT_PIPE2;
      end
      `IOLC_CLS_WC_MOVE: begin
        next_decodePath = `IOLC_PATH_MICRO;
        next_wcUse      = 1'b1;
        next_latency    = `IOLC_LAT_WC;
      end
      `IOLC_CLS_SIZED_OP: begin
        next_latency = selTriple(opSize, `IOLC_LAT_SZ16,
                                 `IOLC_LAT_SZ32,
                                 `IOLC_LAT_SZ64);
      end
      `IOLC_CLS_FSTACK_OP: begin
        next_latency = selTriple(precCtl, `IOLC_LAT_FP_SGL,
                                 `IOLC_LAT_FP_DBL,
                                 `IOLC_LAT_FP_EXT);
      end
      `IOLC_CLS_BIT_OP: begin
        // memory form steps up to microcode
        next_decodePath = memForm ? `IOLC_PATH_MICRO
                                  : `IOLC_PATH_DUAL;
        next_latency    = selRegMem(memForm, `IOLC_LAT_BIT_REG,
                                    `IOLC_LAT_BIT_MEM);
      end
      default: begin
        // unknown class: claim nothing, let the front end trap it
        next_unknownOp  = 1'b1;
        next_decodePath = `IOLC_PATH_MICRO;
        next_latency    = {LAT_W{1'b0}};
        next_pipeMask   = `IOLC_PIPE_NONE;
        next_allocExec  = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer register; fields hold between requests so the scheduler may
  // sample late, but only the outValid pulse marks a fresh answer
  always @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      outValid   <= 1'b0;
      decodePath <= `IOLC_PATH_SINGLE;
      latency    <= {LAT_W{1'b0}};
      pipeMask   <= `IOLC_PIPE_NONE;
      uopSlots   <= 2'h0;
      allocExec  <= 1'b0;
      wcUse      <= 1'b0;
      unknownOp  <= 1'b0;
      dstReg     <= {REG_W{1'b0}};
      srcReg     <= {REG_W{1'b0}};
    end else begin
      outValid <= reqValid;
      if (reqValid) begin
        decodePath <= next_decodePath;
        latency    <= next_latency;
        pipeMask   <= next_pipeMask;
        uopSlots   <= next_allocExec ? slotsOf(next_decodePath)
                                     : 2'h0;
        allocExec  <= next_allocExec;
        wcUse      <= next_wcUse;
        unknownOp  <= next_unknownOp;
        dstReg     <= firstReg;
        srcReg     <= secondReg;
      end
    end
  end

endmodule

`default_nettype wire

// [rtl/iolc_classifier_note_end.v]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [dv/iolc_sched_model.sv]
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module iolc_sched_model (
  // answer from the classifier
  input  wire        mclk,
  input  wire        outValid,
  input  wire        allocExec,
  input  wire  [2:0] pipeMask,
  // issue record
  output logic [1:0] issuePipe,
  output logic [7:0] issued
);
  initial issued = 8'h00;
  // lowest allowed pipe wins; idle answers never take a slot
  always @(posedge mclk) begin
    if (outValid && allocExec) begin
      issuePipe <= pipeMask[0] ? 2'h0 : (pipeMask[1] ? 2'h1 : 2'h2);
      issued    <= issued + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [dv/iolc_classifier_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
`include "iolc_defines.vh"
////////////////////////////////////////////////////////////////////////
module iolc_classifier_asserts #(
  parameter CLS_W = 5,
  parameter LAT_W = 8,
  parameter REG_W = 4
) (
  // request side
  input wire             mclk,
  input wire             rst_b,
  input wire             reqValid,
  input wire [CLS_W-1:0] opClass,
  input wire             memForm,
  input wire             eaScaled,
  input wire [1:0]       eaSrcCount,
  input wire             laterVariant,
  // answer side
  input wire             outValid,
  input wire [1:0]       decodePath,
  input wire [LAT_W-1:0] latency,
  input wire [2:0]       pipeMask,
  input wire [1:0]       uopSlots,
  input wire             allocExec,
  input wire             wcUse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // every request answered one cycle later, nothing else
  AST_ANSWER: assert property (reqValid |=> outValid)
    else $error("answer missing");
  AST_IDLE: assert property (
    !reqValid |=> !outValid && $stable(latency)) else $error("idle change");
  AST_ALU_MEM: assert property (
    reqValid && opClass < `IOLC_CLS_ADJ_ADD && memForm |=>
    latency == `IOLC_LAT_ALU_MEM && decodePath == `IOLC_PATH_SINGLE)
    else $error("alu memory form wrong");
  AST_ADJ_MUL: assert property (
    reqValid && opClass == `IOLC_CLS_ADJ_MUL |=>
    latency == ($past(laterVariant) ? 8'h0f : 8'h0e)) else $error("adj mul");
  AST_EA: assert property (
    reqValid && opClass == `IOLC_CLS_EA_CALC |=> latency ==
    (($past(eaScaled) || $past(eaSrcCount) > 2'h2) ? 8'h02 : 8'h01))
    else $error("address calc latency");
  AST_PIPE0: assert property (
    reqValid && opClass == `IOLC_CLS_INT_MUL |=> pipeMask == 3'h1)
    else $error("pipe 0 restriction");
  AST_PIPE2: assert property (
    reqValid && opClass == `IOLC_CLS_PIPE2_OP |=> pipeMask == 3'h4)
    else $error("pipe 2 restriction");
  AST_NOP: assert property (
    reqValid && opClass == `IOLC_CLS_NOP |=> !allocExec && uopSlots == 2'h0)
    else $error("nop uses resources");
  AST_WC: assert property (
    reqValid |=> wcUse == ($past(opClass) == `IOLC_CLS_WC_MOVE))
    else $error("write combining flag");
  AST_SLOTS: assert property (
    outValid && allocExec |-> uopSlots == decodePath + 2'h1)
    else $error("slots against path");
  cover property (reqValid ##1 reqValid);
  cover property (reqValid && opClass[4]);
  cover property (reqValid && opClass == `IOLC_CLS_ADJ_MUL && laterVariant);
endmodule
bind iolc_classifier iolc_classifier_asserts #(.CLS_W(CLS_W),
  .LAT_W(LAT_W), .REG_W(REG_W)) iolc_classifier_asserts_inst (.mclk,
  .rst_b, .reqValid, .opClass, .memForm, .eaScaled, .eaSrcCount,
  .laterVariant, .outValid, .decodePath, .latency, .pipeMask, .uopSlots,
  .allocExec, .wcUse);
`default_nettype wire

// [dv/iolc_classifier_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "iolc_defines.vh"
////////////////////////////////////////////////////////////////////////
module iolc_classifier_tb_top;
  typedef struct packed {
    logic [4:0] c; logic m; logic [1:0] sz; logic [1:0] pc; logic sc;
    logic [1:0] n; logic lv; logic [1:0] p; logic [7:0] l; logic [2:0] k;
  } iolc_row_t;
  logic       mclk, rst_b, reqValid, memForm, eaScaled, laterVariant;
  logic [4:0] opClass;
  logic [1:0] opSize, precCtl, eaSrcCount, decodePath, uopSlots, issuePipe;
  logic [3:0] firstReg, secondReg, dstReg, srcReg;
  logic       outValid, allocExec, wcUse, unknownOp;
  logic [7:0] latency, issued, cnt;
  logic [2:0] pipeMask;
  int         err_count, compares;
  iolc_row_t  rows[$];
  iolc_classifier iolc_classifier_inst (.mclk, .rst_b, .reqValid, .opClass,
    .memForm, .opSize, .precCtl, .eaScaled, .eaSrcCount, .laterVariant,
    .firstReg, .secondReg, .outValid, .decodePath, .latency, .pipeMask,
    .uopSlots, .allocExec, .wcUse, .unknownOp, .dstReg, .srcReg);
  iolc_sched_model iolc_sched_model_inst (.mclk, .outValid, .allocExec,
    .pipeMask, .issuePipe, .issued);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // mask 0 marks a class that takes no execution slot at all
  task automatic r(input logic [4:0] c, input logic m, input logic [1:0] sz,
      pc, input logic sc, input logic [1:0] n, input logic lv,
      input logic [1:0] p, input logic [7:0] l, input logic [2:0] k);
    rows.push_back('{c, m, sz, pc, sc, n, lv, p, l, k});
  endtask
  // called just after a falling edge; the next rising edge takes it
  task automatic req(input iolc_row_t x);
    {opClass, memForm, opSize, precCtl} = {x.c, x.m, x.sz, x.pc};
    {eaScaled, eaSrcCount, laterVariant} = {x.sc, x.n, x.lv};
    firstReg = x.c[3:0];
    secondReg = ~x.c[3:0];
    reqValid = 1'b1;
  endtask
  task automatic ans(input iolc_row_t x);
    chk("outValid", outValid, 1);
    chk("latency", latency, x.l);
    chk("path", decodePath, x.p);
    chk("pipeMask", pipeMask, x.k);
    chk("allocExec", allocExec, x.k != 3'h0);
    chk("uopSlots", uopSlots, (x.k != 3'h0) ? x.p + 8'h01 : 8'h00);
    chk("wcUse", wcUse, x.c == `IOLC_CLS_WC_MOVE);
    chk("unknownOp", unknownOp, x.c[4]);
    chk("dstReg", dstReg, x.c[3:0]);
    chk("srcReg", srcReg, {4'h0, ~x.c[3:0]});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // a hang costs far more than the 71 cycles the run needs
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
  initial begin
    {rst_b, reqValid, memForm, eaScaled, laterVariant} = 5'h00;
    {opClass, opSize, precCtl, eaSrcCount, firstReg, secondReg} = 19'h0;
    r(0,0,0,0,0,2,0,0,1,7); r(1,1,0,0,0,2,0,0,4,7); r(2,1,0,0,0,2,0,0,4,7);
    r(3,0,0,0,0,2,0,2,5,7); r(4,0,0,0,0,2,0,2,5,7); r(5,0,0,0,0,2,0,2,14,7);
    r(5,0,0,0,0,2,1,2,15,7); r(6,0,0,0,0,2,0,2,5,7); r(7,1,0,0,0,2,0,0,6,7);
    r(7,0,0,0,0,2,0,0,4,7); r(8,0,0,0,0,2,0,0,1,7); r(8,0,0,0,1,2,0,0,2,7);
    r(8,0,0,0,0,3,0,0,2,7); r(10,1,0,0,0,2,0,0,6,1); r(11,0,0,0,0,2,0,0,1,4);
    r(12,0,0,0,0,2,0,2,6,7); r(13,0,3,0,0,2,0,0,1,7); r(14,0,0,0,0,2,0,0,26,7);
    r(14,0,0,1,0,2,0,0,42,7); r(14,0,0,3,0,2,0,0,74,7); r(15,0,0,0,0,2,0,1,2,7);
    r(15,1,0,0,0,2,0,2,5,7); r(9,0,0,0,0,2,0,0,0,0); r(16,0,0,0,0,2,0,2,0,0);
    r(14,0,0,2,0,2,0,0,74,7); r(13,0,0,0,0,2,0,0,1,7); r(8,0,0,0,0,1,0,0,1,7);
    repeat (6) @(negedge mclk);
    chk("rstValid", outValid, 0);
    chk("rstLat", latency, 0);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    foreach (rows[i]) begin
      cnt = issued;
      req(rows[i]);
      @(negedge mclk);
      ans(rows[i]);
      reqValid = 1'b0;
      @(negedge mclk);
      chk("dropValid", outValid, 0);
      chk("holdLat", latency, rows[i].l);
      chk("issued", issued, cnt + (rows[i].l != 0));
      if (rows[i].k == 3'h1) chk("pipe0", issuePipe, 0);
      if (rows[i].k == 3'h4) chk("pipe2", issuePipe, 2);
    end
    // back to back: memory form, then the later multiply adjust
    req(rows[1]);
    @(negedge mclk);
    ans(rows[1]);
    req(rows[6]);
    @(negedge mclk);
    ans(rows[6]);
    // reset in mid request clears the answer
    req(rows[0]);
    rst_b = 1'b0;
    @(negedge mclk);
    chk("midValid", outValid, 0);
    chk("midLat", latency, 0);
    reqValid = 1'b0;
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    req(rows[13]);
    @(negedge mclk);
    ans(rows[13]);
    reqValid = 1'b0;
    @(negedge mclk);
    give_verdict();
  end
endmodule
`default_nettype wire
